/* File: spisr_cfg.svh */
// constants of the serial status/data block: register indexes, reset values
// assumes 32-bit apb with one register per aligned word (byte address = 4 * index)
`ifndef SPISR_CFG_SVH
`define SPISR_CFG_SVH

// register indexes, byte address is four times the index
`define SPISR_IDX_STAT 8'hc4
`define SPISR_IDX_DATA 8'hc5
`define SPISR_IDX_IRQS 8'hc6
`define SPISR_IDX_IRQM 8'hc7
`define SPISR_IDX_CTRL 8'hd4

// apb address width in bits
`define SPISR_AW 12

// reset values
`define SPISR_CTRL_RST 8'h14
`define SPISR_STAT_RST 8'h08
`define SPISR_IRQM_RST 3'h7
`define SPISR_SYNC_RST 4'hf

// sticky interrupt bit positions
`define SPISR_IRQ_DONE 0
`define SPISR_IRQ_TXE  1
`define SPISR_IRQ_MODE_FAULT_FLAG 2

// bytes are eight bits, master frame is sixteen half periods
`define SPISR_BITS  4'h8
`define SPISR_HALVES 5'h10

`endif

/* File: spisr_pkg.sv */
// types of the serial status/data block
// assumes spisr_cfg.svh supplies the numeric constants
package spisr_pkg;

   // exchange engine state
   typedef enum logic [0:0] {st_idle, st_run} spisr_state_e;

   // register selected by an apb address
   typedef enum logic [2:0] {
      reg_none, reg_stat, reg_data, reg_irqs, reg_irqm, reg_ctrl
   } spisr_reg_e;

   // control register layout, bit 7 first
   typedef struct packed {
      logic rate_hi;     // clock_rate_select_hi
      logic en;          // interface_enable_bit
      logic select_pin_disable;       // select_pin_disable
      logic master_role_select;        // master_role_select
      logic cpol;        // idle level of sck
      logic cpha;        // sample on returning edge
      logic rate_mid;    // clock_rate_select_mid
      logic rate_lo;     // clock_rate_select_lo
   } spisr_ctrl_s;

   // status and interrupt-control layout, bit 7 first
   typedef struct packed {
      logic done;        // transfer_done_flag
      logic rsvd;        // reserved, reads zero
      logic overrun_flag;         // overrun_flag
      logic mode_fault_flag;        // mode_fault_flag
      logic txe;         // tx_empty_flag
      logic lsb_first;   // lsb_first_select
      logic txe_ie;      // tx_empty_irq_enable
      logic mode_fault_flag_ie;     // mode_fault_irq_enable
   } spisr_stat_s;

   // synchronised serial pins
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } spisr_pins_s;

endpackage

/* File: spisr_sync.sv */
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to clk; only q is read downstream
module spisr_sync #(
   parameter int          W   = 4,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;   // first stage, read only by q

   // two stages, reset to a constant level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST;
         q      <= RST;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

/* File: spisr_top.sv */
// serial interface status, interrupt control and data buffer with apb access
// assumes pins are asynchronous to pclk; apb master follows the apb protocol
`include "spisr_cfg.svh"

module spisr_top (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`SPISR_AW-1:0]   paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   sck_i,
   output logic                        sck_o,
   output logic                        sck_oe,
   input  wire logic                   mosi_i,
   output logic                        mosi_o,
   output logic                        mosi_oe,
   input  wire logic                   miso_i,
   output logic                        miso_o,
   output logic                        miso_oe,
   input  wire logic                   ss_n_i,
   output logic                        irq
);
   import spisr_pkg::*;

   // address decode, word aligned only
   function automatic spisr_reg_e dec_reg(input logic [`SPISR_AW-1:0] a);
      spisr_reg_e r;
      r = reg_none;
      if (a[1:0] == 2'h0) begin
         case (a[`SPISR_AW-1:2])
            {2'h0, `SPISR_IDX_STAT}: r = reg_stat;
            {2'h0, `SPISR_IDX_DATA}: r = reg_data;
            {2'h0, `SPISR_IDX_IRQS}: r = reg_irqs;
            {2'h0, `SPISR_IDX_IRQM}: r = reg_irqm;
            {2'h0, `SPISR_IDX_CTRL}: r = reg_ctrl;
            default:                 r = reg_none;
         endcase
      end
      return r;
   endfunction

   // half sck period in pclk cycles, minus one
   function automatic logic [6:0] half_m1(input logic [2:0] code);
      logic [6:0] h;
      h = 7'h3f;                               // invalid codes run slowest
      if (code != 3'h0 && code != 3'h7) begin
         h = 7'((7'h1 << code) - 7'h1);
      end
      return h;
   endfunction

   // synchronised pins
   spisr_pins_s pin_s;
   spisr_sync #(
      .W   (4),
      .RST (`SPISR_SYNC_RST)
   ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({sck_i, mosi_i, miso_i, ss_n_i}),
      .q     (pin_s)
   );

   // register state
   spisr_ctrl_s ctrl_q, ctrl_d;         // control
   spisr_stat_s stat_q, stat_d;         // status and irq control
   logic [7:0]  rxbuf_q, rxbuf_d;       // receive buffer
   logic        arm_q, arm_d;           // done clear armed by status read
   logic [2:0]  irqs_q, irqs_d;         // sticky interrupt status
   logic [2:0]  irqm_q, irqm_d;         // interrupt mask
   logic        irq_d;
   logic [31:0] prdata_d;
   logic        pready_d, pslverr_d;

   // engine state
   spisr_state_e st_q, st_d;
   logic [7:0]  sh_q, sh_d;             // transmit shift register
   logic [7:0]  rx_q, rx_d;             // receive shift register
   logic [4:0]  cnt_q, cnt_d;           // ticks (master) or samples (slave)
   logic [6:0]  div_q, div_d;           // half period divider
   logic        ph_q, ph_d;             // master sck phase, 0 is idle
   logic        first_q, first_d;       // first shift edge still pending
   logic        sck_prev_q;             // previous synced sck

   // engine events
   logic        ev_xfer;                // byte complete
   logic        ev_mf;                  // mode fault detected
   logic        ev_wovr;                // data written mid-exchange
   logic        ev_load;                // data write accepted

   // apb phase terms
   spisr_reg_e  sel_reg;
   logic        acc_end;
   logic        wr_data, rd_data, rd_stat;
   assign sel_reg = dec_reg(paddr);
   assign acc_end = psel & penable & pready;
   assign wr_data = acc_end & pwrite & (sel_reg == reg_data);
   assign rd_data = acc_end & !pwrite & (sel_reg == reg_data);
   assign rd_stat = acc_end & !pwrite & (sel_reg == reg_stat);

   // serial edge terms
   logic        sel_s, lvl, lvl_prev, tick, lead, trail, sample_ev, shift_ev, in_bit;
   assign sel_s     = ctrl_q.select_pin_disable | !pin_s.ss_n;
   assign lvl       = pin_s.sck ^ ctrl_q.cpol;
   assign lvl_prev  = sck_prev_q ^ ctrl_q.cpol;
   assign tick      = (div_q == half_m1({ctrl_q.rate_hi, ctrl_q.rate_mid, ctrl_q.rate_lo}));
   assign lead      = ctrl_q.master_role_select ? (tick & !ph_q) : (lvl & !lvl_prev);
   assign trail     = ctrl_q.master_role_select ? (tick & ph_q) : (!lvl & lvl_prev);
   assign sample_ev = ctrl_q.cpha ? trail : lead;
   assign shift_ev  = ctrl_q.cpha ? lead : trail;
   assign in_bit    = ctrl_q.master_role_select ? pin_s.miso : pin_s.mosi;

   // exchange engine next state
   always_comb begin
      st_d    = st_q;
      sh_d    = sh_q;
      rx_d    = rx_q;
      cnt_d   = cnt_q;
      div_d   = div_q;
      ph_d    = ph_q;
      first_d = first_q;
      ev_xfer = 1'b0;
      ev_mf   = 1'b0;
      ev_wovr = 1'b0;
      ev_load = 1'b0;
      if (!ctrl_q.en) begin
         // disabled: engine idle, counters, divider and phase held at reset values, shift registers keep their contents
         st_d    = st_idle;
         cnt_d   = 5'h0;
         div_d   = 7'h0;
         ph_d    = 1'b0;
         first_d = 1'b1;
      end else begin
         case (st_q)
            st_idle: begin
               if (ctrl_q.master_role_select & !ctrl_q.select_pin_disable & pin_s.ss_n == 1'b0) begin
                  ev_mf = 1'b1;
               end else if (wr_data) begin
                  // write goes straight to the shifter
                  sh_d    = pwdata[7:0];
                  ev_load = 1'b1;
                  if (ctrl_q.master_role_select) begin
                     st_d    = st_run;
                     cnt_d   = 5'h0;
                     div_d   = 7'h0;
                     ph_d    = 1'b0;
                     first_d = 1'b1;
                  end
               end else if (!ctrl_q.master_role_select & sel_s) begin
                  // slave selected: fresh exchange
                  st_d    = st_run;
                  cnt_d   = 5'h0;
                  first_d = 1'b1;
               end
            end
            st_run: begin
               ev_wovr = wr_data;
               if (ctrl_q.master_role_select & !ctrl_q.select_pin_disable & !pin_s.ss_n) begin
                  ev_mf = 1'b1;
                  st_d  = st_idle;
               end else if (!ctrl_q.master_role_select & !sel_s) begin
                  // slave deselected mid-exchange: fault, drop the byte
                  ev_mf = 1'b1;
                  st_d  = st_idle;
               end else begin
                  if (sample_ev) begin
                     rx_d = stat_q.lsb_first ? {in_bit, rx_q[7:1]}
                                             : {rx_q[6:0], in_bit};
                  end
                  if (shift_ev) begin
                     first_d = 1'b0;
                     if (!(ctrl_q.cpha & first_q)) begin
                        sh_d = stat_q.lsb_first ? {1'b0, sh_q[7:1]}
                                                : {sh_q[6:0], 1'b0};
                     end
                  end
                  if (ctrl_q.master_role_select) begin
                     // master: sixteen half periods per byte
                     div_d = tick ? 7'h0 : 7'(div_q + 7'h1);
                     if (tick) begin
                        ph_d  = !ph_q;
                        cnt_d = 5'(cnt_q + 5'h1);
                        if (cnt_q == `SPISR_HALVES - 5'h1) begin
                           ev_xfer = 1'b1;
                           st_d    = st_idle;
                        end
                     end
                  end else if (sample_ev) begin
                     // slave: eight samples per byte, stay selected
                     cnt_d = 5'(cnt_q + 5'h1);
                     if (cnt_q == {1'b0, `SPISR_BITS - 4'h1}) begin
                        ev_xfer = 1'b1;
                        cnt_d   = 5'h0;
                        first_d = 1'b1;
                     end
                  end
               end
            end
            default: st_d = st_idle;
         endcase
      end
   end

   // engine registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q       <= st_idle;
         sh_q       <= 8'h00;
         rx_q       <= 8'h00;
         cnt_q      <= 5'h00;
         div_q      <= 7'h00;
         ph_q       <= 1'b0;
         first_q    <= 1'b1;
         sck_prev_q <= 1'b1;
      end else begin
         st_q       <= st_d;
         sh_q       <= sh_d;
         rx_q       <= rx_d;
         cnt_q      <= cnt_d;
         div_q      <= div_d;
         ph_q       <= ph_d;
         first_q    <= first_d;
         sck_prev_q <= pin_s.sck;
      end
   end

   // register file, flags and interrupt next state
   always_comb begin
      ctrl_d    = ctrl_q;
      stat_d    = stat_q;
      rxbuf_d   = rxbuf_q;
      arm_d     = arm_q;
      irqs_d    = irqs_q;
      irqm_d    = irqm_q;
      prdata_d  = prdata;
      pready_d  = psel & penable & !pready;
      pslverr_d = psel & penable & !pready & (sel_reg == reg_none);
      // read data prepared one cycle before pready
      if (psel & penable & !pready) begin
         case (sel_reg)
            reg_stat: prdata_d = {24'h0, stat_q.done, 1'b0, stat_q[5:0]};
            reg_data: prdata_d = {24'h0, rxbuf_q};
            reg_irqs: prdata_d = {29'h0, irqs_q};
            reg_irqm: prdata_d = {29'h0, irqm_q};
            reg_ctrl: prdata_d = {24'h0, ctrl_q};
            default:  prdata_d = 32'h0;
         endcase
      end
      // software writes
      if (acc_end & pwrite) begin
         case (sel_reg)
            reg_stat: stat_d[2:0] = pwdata[2:0];
            reg_irqs: irqs_d      = irqs_q & ~pwdata[2:0];
            reg_irqm: irqm_d      = pwdata[2:0];
            reg_ctrl: ctrl_d      = pwdata[7:0];
            default:  ;
         endcase
      end
      // status read arms done clear, clears fault flags
      if (rd_stat) begin
         arm_d       = stat_q.done;
         stat_d.overrun_flag  = 1'b0;
         stat_d.mode_fault_flag = 1'b0;
      end
      // data access after armed status read clears done
      if ((rd_data | wr_data) & arm_q) begin
         stat_d.done = 1'b0;
         arm_d       = 1'b0;
      end
      // transmit register occupancy
      if (ev_load) begin
         stat_d.txe = 1'b0;
      end
      if (!ctrl_q.en) begin
         stat_d.txe = 1'b1;
      end
      // byte complete: keep unread byte on overrun, set wins over clear
      if (ev_xfer) begin
         stat_d.txe = 1'b1;
         if (stat_d.done) begin
            stat_d.overrun_flag = 1'b1;
         end else begin
            rxbuf_d     = rx_d;
            stat_d.done = 1'b1;
         end
      end
      if (ev_wovr) begin
         stat_d.overrun_flag = 1'b1;
      end
      // mode fault
      if (ev_mf) begin
         stat_d.mode_fault_flag = 1'b1;
         if (ctrl_q.master_role_select) begin
            ctrl_d.en = 1'b0;
         end
      end
      // sticky events: done only while txe_ie is clear, txe only while txe_ie is set, mode fault by its enable
      if (stat_d.done & !stat_q.done & !stat_q.txe_ie) begin
         irqs_d[`SPISR_IRQ_DONE] = 1'b1;
      end
      if (stat_d.txe & !stat_q.txe & stat_q.txe_ie) begin
         irqs_d[`SPISR_IRQ_TXE] = 1'b1;
      end
      if (ev_mf & stat_q.mode_fault_flag_ie & !ctrl_q.select_pin_disable) begin
         irqs_d[`SPISR_IRQ_MODE_FAULT_FLAG] = 1'b1;
      end
      irq_d = |(irqs_d & irqm_d);
   end

   // register file flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= `SPISR_CTRL_RST;
         stat_q  <= `SPISR_STAT_RST;
         rxbuf_q <= 8'h00;
         arm_q   <= 1'b0;
         irqs_q  <= 3'h0;
         irqm_q  <= `SPISR_IRQM_RST;
         irq     <= 1'b0;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         stat_q  <= stat_d;
         rxbuf_q <= rxbuf_d;
         arm_q   <= arm_d;
         irqs_q  <= irqs_d;
         irqm_q  <= irqm_d;
         irq     <= irq_d;
         prdata  <= prdata_d;
         pready  <= pready_d;
         pslverr <= pslverr_d;
      end
   end

   // pin drive next values
   logic sck_o_d, sck_oe_d, mosi_o_d, mosi_oe_d, miso_o_d, miso_oe_d, out_bit;
   always_comb begin
      out_bit   = stat_q.lsb_first ? sh_d[0] : sh_d[7];
      sck_o_d   = ctrl_q.cpol ^ (ph_d & (st_d == st_run));
      sck_oe_d  = ctrl_q.en & ctrl_q.master_role_select;
      mosi_o_d  = out_bit;
      mosi_oe_d = ctrl_q.en & ctrl_q.master_role_select;
      miso_o_d  = out_bit;
      miso_oe_d = ctrl_q.en & !ctrl_q.master_role_select & sel_s;
   end

   // pin flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_o   <= 1'b0;
         sck_oe  <= 1'b0;
         mosi_o  <= 1'b0;
         mosi_oe <= 1'b0;
         miso_o  <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         sck_o   <= sck_o_d;
         sck_oe  <= sck_oe_d;
         mosi_o  <= mosi_o_d;
         mosi_oe <= mosi_oe_d;
         miso_o  <= miso_o_d;
         miso_oe <= miso_oe_d;
      end
   end

endmodule

/* File: spisr_asserts.sv */
// checker of apb timing, pin enables and interrupt clearing
// assumes bound to spisr_top and sees only its ports
`include "spisr_cfg.svh"
module spisr_asserts (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [`SPISR_AW-1:0] paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 sck_o,
   input wire logic                 sck_oe,
   input wire logic                 mosi_oe,
   input wire logic                 miso_oe,
   input wire logic                 irq
);
   // byte addresses of the watched registers
   localparam logic [11:0] A_CT = 12'(`SPISR_IDX_CTRL * 4);
   localparam logic [11:0] A_IS = 12'(`SPISR_IDX_IRQS * 4);
   localparam logic [11:0] A_IM = 12'(`SPISR_IDX_IRQM * 4);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // setup cycle, then first access cycle
   sequence s_start;
      psel && !penable ##1 psel && penable;
   endsequence
   // write completing at this edge
   sequence s_wr;
      psel && penable && pready && pwrite;
   endsequence
   AST_ONE_WAIT: assert property (s_start |=> pready ##1 !pready)
      else $error("ready is not one pulse after one wait");
   AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response without ready or with data");
   AST_DIS_STOPS: assert property (s_wr ##0 (paddr == A_CT && !pwdata[6]) |-> ##2 !sck_oe && !mosi_oe)
      else $error("pins still driven after disable");
   AST_MASK_QUIET: assert property (s_wr ##0 (paddr == A_IM && pwdata[2:0] == 3'h0) |-> ##2 !irq)
      else $error("irq high with all sources masked");
   AST_CLR_QUIET: assert property (s_wr ##0 (paddr == A_IS && pwdata[2:0] == 3'h7) |-> ##2 !irq)
      else $error("irq high after clearing all sources");
   AST_OE_PAIR: assert property (mosi_oe == sck_oe)
      else $error("clock and data enables differ");
   AST_MISO_SLV: assert property (miso_oe |-> !sck_oe)
      else $error("slave output driven in master role");
   AST_SCK_HALF: assert property ($changed(sck_o) && sck_oe |=> $stable(sck_o) || !sck_oe)
      else $error("serial clock half period below two cycles");
endmodule

bind spisr_top spisr_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .sck_o, .sck_oe, .mosi_oe, .miso_oe, .irq);

/* File: spisr_slave_model.sv */
// external serial slave answering the block in master role
// assumes clock idle low, sample on leading edge; select from bench
module spisr_slave_model (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       sel_n,
   input  wire logic       lsb,
   input  wire logic [7:0] tx,
   output logic            miso,
   output logic [7:0]      rx
);
   logic [7:0] sh;  // outgoing bits
   initial miso = 1'b1;
   // load reply and show first bit on select
   always @(negedge sel_n) begin
      sh = tx;
      miso = lsb ? tx[0] : tx[7];
   end
   // released line shows the inverse of the last bit
   always @(posedge sel_n) miso = ~miso;
   // capture on leading edge
   always @(posedge sck) if (!sel_n) rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
   // next bit on trailing edge
   always @(negedge sck) if (!sel_n) begin
      sh = lsb ? sh >> 1 : sh << 1;
      miso = lsb ? sh[0] : sh[7];
   end
endmodule

/* File: test_spisr_top.sv */
// self-checking bench of the serial status/data block in master and slave role
// assumes spisr_slave_model on the far side and the bound checker
`include "spisr_cfg.svh"
module test_spisr_top;
   timeunit 1ns;
   timeprecision 1ns;
   import spisr_pkg::*;
   localparam logic [11:0] A_ST = 12'(`SPISR_IDX_STAT * 4);
   localparam logic [11:0] A_DT = 12'(`SPISR_IDX_DATA * 4);
   localparam logic [11:0] A_IS = 12'(`SPISR_IDX_IRQS * 4);
   localparam logic [11:0] A_IM = 12'(`SPISR_IDX_IRQM * 4);
   localparam logic [11:0] A_CT = 12'(`SPISR_IDX_CTRL * 4);
   logic        pclk = 1'b0;     // 20 mhz bus clock
   logic        presetn = 1'b0;  // held low at start
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, miso_m;
   logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
   logic        ss_n = 1'b1;     // select pin, idle high
   logic        sck_m = 1'b0;    // link clock when bench is master
   logic        mosi_m = 1'b0;   // link data when bench is master
   logic        sel_n = 1'b1;    // far side select
   logic        lsb = 1'b0;      // far side bit order
   logic [7:0]  mtx = 8'h0;      // far side reply
   logic [7:0]  mrx;             // far side capture
   int          err_count = 0;
   int          cmp_count = 0;
   // wire levels from all enables
   wire         sck_w = sck_oe ? sck_o : sck_m;
   wire         mosi_w = mosi_oe ? mosi_o : mosi_m;
   wire         miso_w = miso_oe ? miso_o : miso_m;
   spisr_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .sck_i(sck_w), .sck_o, .sck_oe, .mosi_i(mosi_w), .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o,
      .miso_oe, .ss_n_i(ss_n), .irq);
   spisr_slave_model far_u (.sck(sck_w), .mosi(mosi_w), .sel_n, .lsb, .tx(mtx), .miso(miso_m), .rx(mrx));
   always #25 pclk = ~pclk;
   // compare and count
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      cmp_count++;
      if (s !== x) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic tally_and_finish;
      if (err_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one apb transfer, waits for ready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // answer taken at the rising edge that samples pready high
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk($sformatf("reg_%h", a), r, {24'h0, x});
   endtask
   // bounded wait for the interrupt line
   task automatic wait_irq;
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (irq !== 1'b1 && n < 500);
      chk("irq", {31'h0, irq}, 32'h1);
   endtask
   // one byte exchange, control left untouched meanwhile
   task automatic xfer(input logic [7:0] d, input logic two);
      mtx <= 8'($urandom);
      sel_n <= 1'b0;
      wr(A_DT, d);
      if (two)
         wr(A_DT, ~d);
      wait_irq;
      @(posedge pclk) sel_n <= 1'b1;
      chk("far_rx", {24'h0, mrx}, {24'h0, d});
   endtask
   // main sequence
   initial begin
      logic [31:0] r;
      logic        e;
      logic [7:0]  d, m1, t;
      void'($urandom(32'h7c86));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc(A_ST, 8'h08);
      rdc(A_CT, 8'h14);
      apb(1'b0, 12'h004, 32'h0, r, e);
      chk("slverr", {31'h0, e}, 32'h1);
      wr(A_CT, 8'h72);
      // both bit orders, both interrupt sources
      for (int i = 0; i < 4; i++) begin
         lsb <= i[0];
         wr(A_ST, {5'h0, i[0], i[1], 1'b0});
         d = 8'($urandom);
         xfer(d, 1'b0);
         rdc(A_IS, i[1] ? 8'h02 : 8'h01);
         wr(A_IS, 8'h07);
         rdc(A_ST, {4'h8, 1'b1, i[0], i[1], 1'b0});
         rdc(A_DT, mtx);
         rdc(A_ST, {4'h0, 1'b1, i[0], i[1], 1'b0});
      end
      // second byte lands while done still set
      d = 8'($urandom);
      xfer(d, 1'b0);
      m1 = mtx;
      wr(A_IS, 8'h07);
      xfer(~d, 1'b0);
      wr(A_IS, 8'h07);
      rdc(A_ST, 8'hae);
      rdc(A_DT, m1);
      rdc(A_ST, 8'h0e);
      // data write while shifting
      xfer(d, 1'b1);
      wr(A_IS, 8'h07);
      rdc(A_ST, 8'hae);
      rdc(A_DT, mtx);
      // disable in mid exchange
      wr(A_DT, d);
      wr(A_CT, 8'h32);
      rdc(A_ST, 8'h0e);
      rdc(A_IS, 8'h02);
      wr(A_IS, 8'h07);
      // select low ignored when pin disabled
      wr(A_ST, 8'h01);
      wr(A_CT, 8'h72);
      ss_n <= 1'b0;
      repeat (20) @(posedge pclk);
      @(negedge pclk);
      chk("irq", {31'h0, irq}, 32'h0);
      @(posedge pclk) ss_n <= 1'b1;
      // master mode fault
      wr(A_CT, 8'h52);
      ss_n <= 1'b0;
      wait_irq;
      rdc(A_IS, 8'h04);
      rdc(A_CT, 8'h12);
      rdc(A_ST, 8'h19);
      rdc(A_ST, 8'h09);
      ss_n <= 1'b1;
      wr(A_IS, 8'h07);
      // slave role, bench drives the link msb first, cpol 0 cpha 0
      wr(A_CT, 8'h40);
      t = 8'($urandom);
      d = 8'($urandom);
      wr(A_DT, t);
      ss_n <= 1'b0;
      repeat (8) @(posedge pclk);
      for (int b = 7; b >= 0; b--) begin
         sck_m <= 1'b0;
         mosi_m <= d[b];
         repeat (4) @(posedge pclk);
         m1[b] = miso_w;
         sck_m <= 1'b1;
         repeat (4) @(posedge pclk);
      end
      sck_m <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("slv_miso", {24'h0, m1}, {24'h0, t});
      rdc(A_ST, 8'h89);
      rdc(A_DT, d);
      // deselect of a running slave is a fault, enable stays
      ss_n <= 1'b1;
      repeat (4) @(posedge pclk);
      rdc(A_ST, 8'h19);
      rdc(A_CT, 8'h40);
      wr(A_IM, 8'h00);
      @(negedge pclk);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wr(A_IM, 8'h07);
      @(negedge pclk);
      chk("irq_unmasked", {31'h0, irq}, 32'h1);
      rdc(A_IS, 8'h05);
      wr(A_IS, 8'h07);
      tally_and_finish;
   end
   // watchdog, several times the expected run
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      tally_and_finish;
   end
endmodule
